/* src/fieldbus_process_data_interface.sv */
// cyclic process-data interpreter between a fieldbus master and the drive core.
// assumes the bus board presents all command words with a one-cycle strobe
// and the drive core answers parameter accesses with a one-cycle done pulse.
`include "fieldbus_defines.svh"
`default_nettype none
module fieldbus_process_data_interface
  import fieldbus_pkg::*;
#(
  parameter int TORQUE_STEP_CYCLES = `TORQUE_STEP_CYCLES,
  parameter int MOTOR_STEP_CYCLES = `MOTOR_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] bus_protocol_select,
  input wire logic [2:0] link_loss_action,
  input wire logic master_link_lost,
  input wire logic bus_board_inactive,
  input wire logic cmd_strobe,
  input wire logic [15:0] drive_control_word,
  input wire logic [15:0] speed_reference_word,
  input wire logic [15:0] output_command_word,
  input wire logic [15:0] read_select_word,
  input wire logic [15:0] write_number_word,
  input wire logic [15:0] write_value_word,
  input wire logic [7:0] fault_code,
  input wire logic error_active,
  input wire logic pid_automatic,
  input wire logic undervoltage,
  input wire logic is_remote,
  input wire logic jog_active,
  input wire logic is_clockwise,
  input wire logic is_enabled,
  input wire logic is_running,
  input wire logic signed [13:0] speed_feedback,
  input wire logic [7:0] digital_inputs,
  input wire logic [15:0] param_read_data,
  input wire logic signed [15:0] torque_current_value,
  input wire logic signed [15:0] motor_current_value,
  input wire logic signed [15:0] max_speed_reference,
  input wire logic [4:0] function_bus_assigned,
  input wire logic [4:0] output_bus_assigned,
  input wire logic param_done,
  input wire logic param_missing,
  input wire logic param_out_of_range,
  input wire logic param_read_only,
  output logic [15:0] drive_status_word,
  output logic [15:0] speed_status_word,
  output logic [15:0] digital_input_state,
  output logic [15:0] param_readback_word,
  output logic [15:0] torque_status_word,
  output logic [15:0] motor_status_word,
  output logic remote_cmd,
  output logic jog_cmd,
  output logic clockwise_cmd,
  output logic enable_cmd,
  output logic start_cmd,
  output logic stop_detect,
  output logic fault_reset_pulse,
  output logic store_limits_nv,
  output logic signed [15:0] speed_reference,
  output logic [4:0] bus_outputs,
  output logic [15:0] param_read_number,
  output logic param_write_req,
  output logic [15:0] param_write_number,
  output logic [15:0] param_write_value
);
  link_state_t link_state, next_link_state;
  logic [2:0] word_count;
  logic link_ok;
  logic [4:0] next_funcs;
  logic next_remote, next_jog, next_cw, next_enable, next_start, next_stop_detect;
  logic next_fault_reset_pulse, next_store_limits_nv, prev_reset_bit, next_prev_reset_bit;
  logic signed [15:0] next_speed_reference;
  logic [4:0] next_bus_outputs;
  logic [15:0] next_param_read_number, next_param_write_number, next_param_write_value;
  logic next_param_write_req;
  logic [7:0] bus_fault, next_bus_fault;
  logic assign_fault_ctrl, next_assign_fault_ctrl;
  logic [15:0] last_ctrl, next_last_ctrl;
  logic [15:0] next_drive_status, next_speed_status, next_di_state, next_readback;
  logic [15:0] next_torque_status, next_motor_status;
  logic [15:0] drive_state_value;
  logic signed [15:0] torque_filtered, motor_filtered;

  current_lowpass #(.SHIFT(`FILTER_SHIFT), .STEP_CYCLES(TORQUE_STEP_CYCLES)) torque_filter (
    .core_clk(core_clk),
    .rst(rst),
    .sample(torque_current_value),
    .filtered(torque_filtered)
  );

  current_lowpass #(.SHIFT(`FILTER_SHIFT), .STEP_CYCLES(MOTOR_STEP_CYCLES)) motor_filter (
    .core_clk(core_clk),
    .rst(rst),
    .sample(motor_current_value),
    .filtered(motor_filtered)
  );

  always_comb begin
    if (bus_protocol_select == `PROTO_A_2W || bus_protocol_select == `PROTO_B_2W) begin
      word_count = 3'd2;
    end else if (bus_protocol_select == `PROTO_A_4W || bus_protocol_select == `PROTO_B_4W) begin
      word_count = 3'd4;
    end else if (bus_protocol_select == `PROTO_A_6W || bus_protocol_select == `PROTO_B_6W) begin
      word_count = 3'd6;
    end else begin
      word_count = 3'd0;
    end
  end

  assign link_ok = (word_count != 3'd0) && !master_link_lost && !bus_board_inactive;

  // drive state encoding, bus faults excluded
  always_comb begin
    if (error_active && !(fault_code >= `WRITE_WHILE_ENABLED_FAULT && fault_code <= `NOT_BUS_ASSIGNED_FAULT)) begin
      drive_state_value = `STATE_FAULTED;
    end else if (undervoltage) begin
      drive_state_value = `STATE_UNDERVOLTAGE;
    end else if (is_running) begin
      drive_state_value = `STATE_RUNNING;
    end else begin
      drive_state_value = `STATE_READY;
    end
  end

  // command interpretation
  always_comb begin
    next_link_state = link_ok ? LINK_UP : LINK_DOWN;
    next_remote = remote_cmd;
    next_jog = jog_cmd;
    next_cw = clockwise_cmd;
    next_enable = enable_cmd;
    next_start = start_cmd;
    next_stop_detect = stop_detect;
    next_fault_reset_pulse = 1'b0;
    next_prev_reset_bit = prev_reset_bit;
    next_store_limits_nv = store_limits_nv;
    next_speed_reference = speed_reference;
    next_bus_outputs = bus_outputs;
    next_param_read_number = param_read_number;
    next_param_write_number = param_write_number;
    next_param_write_value = param_write_value;
    next_param_write_req = 1'b0;
    next_bus_fault = bus_fault;
    next_assign_fault_ctrl = assign_fault_ctrl;
    next_last_ctrl = last_ctrl;
    next_funcs = {remote_cmd, jog_cmd, clockwise_cmd, enable_cmd, start_cmd};
    if (!link_ok) begin
      if (link_loss_action == `LOSS_RAMP_STOP) begin
        next_start = 1'b0;
      end else if (link_loss_action == `LOSS_COAST_STOP) begin
        next_enable = 1'b0;
      end else if (link_loss_action == `LOSS_GO_LOCAL) begin
        next_remote = 1'b0;
        next_start = 1'b0;
      end else if (link_loss_action == `LOSS_LOCAL_KEEP) begin
        next_remote = 1'b0;
      end
    end else if (link_state == LINK_DOWN) begin
      next_bus_outputs = 5'h00;
    end else if (cmd_strobe) begin
      // whole command set taken at once
      next_last_ctrl = drive_control_word;
      for (int i = 0; i < 5; i++) begin
        if (drive_control_word[`CTRL_SEL_BASE + i]) begin
          if (function_bus_assigned[i]) begin
            next_funcs[i] = drive_control_word[i];
          end else begin
            next_assign_fault_ctrl = 1'b1;
          end
        end
      end
      {next_remote, next_jog, next_cw, next_enable, next_start} = next_funcs;
      next_stop_detect = drive_control_word[`CTRL_STOP_DETECT];
      next_prev_reset_bit = drive_control_word[`CTRL_FAULT_RESET];
      next_fault_reset_pulse = drive_control_word[`CTRL_SEL_FAULT_RESET] &&
                               drive_control_word[`CTRL_FAULT_RESET] && !prev_reset_bit;
      if (drive_control_word[`CTRL_SEL_STORE]) begin
        next_store_limits_nv = !drive_control_word[`CTRL_NO_STORE];
      end
      // speed reference clamped to configured maximum
      if ($signed(speed_reference_word) > max_speed_reference) begin
        next_speed_reference = max_speed_reference;
      end else if ($signed(speed_reference_word) < -max_speed_reference) begin
        next_speed_reference = -max_speed_reference;
      end else begin
        next_speed_reference = $signed(speed_reference_word);
      end
      // a changed control word selecting no unassigned function clears the assignment fault, unless the output word raises it again
      if (drive_control_word != last_ctrl && !(|(drive_control_word[12:8] & ~function_bus_assigned))) begin
        next_assign_fault_ctrl = 1'b0;
      end
      if (word_count >= 3'd4) begin
        for (int i = 0; i < `OUT_COUNT; i++) begin
          if (output_command_word[`OUT_SEL_BASE + i]) begin
            if (output_bus_assigned[i]) begin
              next_bus_outputs[i] = output_command_word[i];
            end else begin
              next_assign_fault_ctrl = 1'b1;
            end
          end
        end
        next_param_read_number = read_select_word;
      end
      if (word_count == 3'd6) begin
        if (write_number_word == `PARAM_IDLE_NUMBER) begin
          if (bus_fault != `NOT_BUS_ASSIGNED_FAULT) begin
            next_bus_fault = `NO_FAULT;
          end
        end else if (write_number_word != param_write_number || write_value_word != param_write_value) begin
          if (is_enabled) begin
            next_bus_fault = `WRITE_WHILE_ENABLED_FAULT;
          end else begin
            next_param_write_req = 1'b1;
          end
        end
        next_param_write_number = write_number_word;
        next_param_write_value = write_value_word;
      end
    end
    if (param_done) begin
      if (param_missing) begin
        next_bus_fault = `MISSING_PARAMETER_FAULT;
      end else if (param_out_of_range) begin
        next_bus_fault = `VALUE_RANGE_FAULT;
      end else if (param_read_only) begin
        next_bus_fault = `NOT_BUS_ASSIGNED_FAULT;
      end else if (next_bus_fault == bus_fault) begin
        // a fault raised by this cycle's strobe beats a clean result
        next_bus_fault = `NO_FAULT;
      end
    end
  end

  // status words
  always_comb begin
    // status high flags and fault code
    next_drive_status = {error_active, pid_automatic, undervoltage, is_remote, jog_active, is_clockwise,
                         is_enabled, is_running, fault_code};
    if (assign_fault_ctrl) begin
      next_drive_status[7:0] = `NOT_BUS_ASSIGNED_FAULT;
    end else if (bus_fault != `NO_FAULT) begin
      next_drive_status[7:0] = bus_fault;
    end
    next_speed_status = {{2{speed_feedback[13]}}, speed_feedback};
    // input one in bit 7, the top bit of the low byte
    for (int i = 0; i < 8; i++) begin
      next_di_state[7 - i] = digital_inputs[i];
    end
    next_di_state[15:8] = 8'h00;
    next_readback = (param_read_number == `DRIVE_STATE_PARAM) ? drive_state_value : param_read_data;
    next_torque_status = torque_filtered;
    next_motor_status = motor_filtered;
    // words beyond the selected count stay zero
    if (word_count < 3'd2) begin
      next_drive_status = 16'h0000;
      next_speed_status = 16'h0000;
    end
    if (word_count < 3'd4) begin
      next_di_state = 16'h0000;
      next_readback = 16'h0000;
    end
    if (word_count < 3'd6) begin
      next_torque_status = 16'h0000;
      next_motor_status = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_state <= LINK_DOWN;
      remote_cmd <= 1'b0;
      jog_cmd <= 1'b0;
      clockwise_cmd <= 1'b0;
      enable_cmd <= 1'b0;
      start_cmd <= 1'b0;
      stop_detect <= 1'b0;
      fault_reset_pulse <= 1'b0;
      prev_reset_bit <= 1'b0;
      store_limits_nv <= 1'b1;
      speed_reference <= 16'sh0000;
      bus_outputs <= 5'h00;
      param_read_number <= 16'h0000;
      param_write_req <= 1'b0;
      param_write_number <= `PARAM_IDLE_NUMBER;
      param_write_value <= 16'h0000;
      bus_fault <= `NO_FAULT;
      assign_fault_ctrl <= 1'b0;
      last_ctrl <= 16'h0000;
      drive_status_word <= 16'h0000;
      speed_status_word <= 16'h0000;
      digital_input_state <= 16'h0000;
      param_readback_word <= 16'h0000;
      torque_status_word <= 16'h0000;
      motor_status_word <= 16'h0000;
    end else begin
      link_state <= next_link_state;
      remote_cmd <= next_remote;
      jog_cmd <= next_jog;
      clockwise_cmd <= next_cw;
      enable_cmd <= next_enable;
      start_cmd <= next_start;
      stop_detect <= next_stop_detect;
      fault_reset_pulse <= next_fault_reset_pulse;
      prev_reset_bit <= next_prev_reset_bit;
      store_limits_nv <= next_store_limits_nv;
      speed_reference <= next_speed_reference;
      bus_outputs <= next_bus_outputs;
      param_read_number <= next_param_read_number;
      param_write_req <= next_param_write_req;
      param_write_number <= next_param_write_number;
      param_write_value <= next_param_write_value;
      bus_fault <= next_bus_fault;
      assign_fault_ctrl <= next_assign_fault_ctrl;
      last_ctrl <= next_last_ctrl;
      drive_status_word <= next_drive_status;
      speed_status_word <= next_speed_status;
      digital_input_state <= next_di_state;
      param_readback_word <= next_readback;
      torque_status_word <= next_torque_status;
      motor_status_word <= next_motor_status;
    end
  end
endmodule : fieldbus_process_data_interface
`default_nettype wire

/* src/fieldbus_defines.svh */
// fieldbus process-data constants: field positions, codes and timing.
// assumes a 100 MHz core clock; included by bare name.
`ifndef FIELDBUS_DEFINES_SVH
`define FIELDBUS_DEFINES_SVH

`define CLK_PERIOD_NS 10
// protocol selection values
`define PROTO_INACTIVE 3'h0
`define PROTO_A_2W 3'h1
`define PROTO_A_4W 3'h2
`define PROTO_A_6W 3'h3
`define PROTO_B_2W 3'h4
`define PROTO_B_4W 3'h5
`define PROTO_B_6W 3'h6
// link-loss actions
`define LOSS_RAMP_STOP 3'h0
`define LOSS_COAST_STOP 3'h1
`define LOSS_NO_CHANGE 3'h2
`define LOSS_GO_LOCAL 3'h3
`define LOSS_LOCAL_KEEP 3'h4
// control word fields
`define CTRL_START 0
`define CTRL_ENABLE 1
`define CTRL_CW 2
`define CTRL_JOG 3
`define CTRL_REMOTE 4
`define CTRL_NO_STORE 5
`define CTRL_STOP_DETECT 6
`define CTRL_FAULT_RESET 7
`define CTRL_SEL_BASE 8
`define CTRL_SEL_STORE 13
`define CTRL_SEL_FAULT_RESET 15
// output command word
`define OUT_COUNT 5
`define OUT_SEL_BASE 8
// bus-access fault codes
`define WRITE_WHILE_ENABLED_FAULT 8'h18
`define MISSING_PARAMETER_FAULT 8'h19
`define VALUE_RANGE_FAULT 8'h1A
`define NOT_BUS_ASSIGNED_FAULT 8'h1B
`define NO_FAULT 8'h00
// parameter numbers
`define PARAM_IDLE_NUMBER 16'h03E7
`define DRIVE_STATE_PARAM 16'h0006
// drive state codes
`define STATE_READY 16'h0000
`define STATE_RUNNING 16'h0001
`define STATE_UNDERVOLTAGE 16'h0002
`define STATE_FAULTED 16'h0003
// speed scaling
`define SPEED_FULL_SCALE 16'sh1FFF
// current filters
`define FILTER_SHIFT 8
`define TORQUE_TAU_US 500000
`define MOTOR_TAU_US 300000
`define TORQUE_TAU_CYCLES (`TORQUE_TAU_US * 1000 / `CLK_PERIOD_NS)
`define MOTOR_TAU_CYCLES (`MOTOR_TAU_US * 1000 / `CLK_PERIOD_NS)
`define TORQUE_STEP_CYCLES (`TORQUE_TAU_CYCLES / (1 << `FILTER_SHIFT))
`define MOTOR_STEP_CYCLES (`MOTOR_TAU_CYCLES / (1 << `FILTER_SHIFT))

`endif

/* src/fieldbus_pkg.sv */
// types shared by the process-data interpreter.
// assumes nothing beyond the defines header.
`default_nettype none
package fieldbus_pkg;
  typedef enum logic [1:0] {
    LINK_DOWN = 2'b01,
    LINK_UP = 2'b10
  } link_state_t;
endpackage : fieldbus_pkg
`default_nettype wire

/* src/current_lowpass.sv */
// first-order low-pass filter for a signed current value.
// assumes the time constant equals STEP_CYCLES * 2**SHIFT clock cycles.
`default_nettype none
module current_lowpass #(
  parameter int SHIFT = 8,
  parameter int STEP_CYCLES = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic signed [15:0] sample,
  output logic signed [15:0] filtered
);
  logic [31:0] tick_count, next_tick_count;
  logic signed [16+SHIFT-1:0] acc, next_acc;
  logic signed [16+SHIFT-1:0] delta;

  always_comb begin
    next_tick_count = tick_count + 32'h0000_0001;
    next_acc = acc;
    delta = {{SHIFT{sample[15]}}, sample} - (acc >>> SHIFT);
    if (tick_count >= 32'(STEP_CYCLES - 1)) begin
      next_tick_count = 32'h0000_0000;
      // acc tracks the input scaled by 2**SHIFT
      next_acc = acc + delta;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_count <= 32'h0000_0000;
      acc <= '0;
    end else begin
      tick_count <= next_tick_count;
      acc <= next_acc;
    end
  end

  assign filtered = acc[16+SHIFT-1:SHIFT];
endmodule : current_lowpass
`default_nettype wire

/* tb/fieldbus_pdi_properties.sv */
// concurrent checks on the process-data interpreter ports.
// assumes it is bound to the top module, one core_clk domain with async rst.
`default_nettype none
module fieldbus_pdi_properties
  import fieldbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] bus_protocol_select,
  input wire logic [2:0] link_loss_action,
  input wire logic master_link_lost,
  input wire logic bus_board_inactive,
  input wire logic cmd_strobe,
  input wire logic [15:0] drive_control_word,
  input wire logic [4:0] function_bus_assigned,
  input wire logic error_active,
  input wire logic pid_automatic,
  input wire logic undervoltage,
  input wire logic is_remote,
  input wire logic jog_active,
  input wire logic is_clockwise,
  input wire logic is_enabled,
  input wire logic is_running,
  input wire logic signed [13:0] speed_feedback,
  input wire logic [7:0] digital_inputs,
  input wire logic [15:0] drive_status_word,
  input wire logic [15:0] speed_status_word,
  input wire logic [15:0] digital_input_state,
  input wire logic remote_cmd,
  input wire logic start_cmd,
  input wire logic stop_detect,
  input wire logic fault_reset_pulse,
  input wire logic [4:0] bus_outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic link_ok, acc, up_q, b7_q, next_up, next_b7;
  logic [7:0] din_rev;
  assign link_ok = !master_link_lost && !bus_board_inactive && bus_protocol_select inside {[3'h1:3'h6]};
  // a set is taken only once the link was already up one cycle
  assign acc = cmd_strobe && link_ok && up_q;
  always_comb begin
    next_up = link_ok;
    next_b7 = acc ? drive_control_word[7] : b7_q;
    for (int i = 0; i < 8; i++) din_rev[i] = digital_inputs[7 - i];
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_q <= 1'b0;
      b7_q <= 1'b0;
    end else begin
      up_q <= next_up;
      b7_q <= next_b7;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_on; !$past(rst) && ($past(bus_protocol_select) inside {[3'h1:3'h6]}); endsequence
  sequence s_pulse; fault_reset_pulse ##1 !fault_reset_pulse; endsequence
  property p_start; acc && drive_control_word[8] && function_bus_assigned[0] |=> start_cmd == $past(drive_control_word[0]);
  endproperty
  a_start: assert property (p_start) else $error("start command not taken");
  property p_stop; acc |=> stop_detect == $past(drive_control_word[6]); endproperty
  a_stop: assert property (p_stop) else $error("stop detect wrong");
  property p_fault; acc && drive_control_word[15] && drive_control_word[7] && !b7_q |=> s_pulse; endproperty
  a_fault: assert property (p_fault) else $error("fault reset pulse wrong");
  property p_status; s_on |-> drive_status_word[15:8] == $past({error_active, pid_automatic, undervoltage,
    is_remote, jog_active, is_clockwise, is_enabled, is_running}); endproperty
  a_status: assert property (p_status) else $error("status high byte wrong");
  property p_din; s_on ##0 ($past(bus_protocol_select) inside {3'h2, 3'h3, 3'h5, 3'h6})
    |-> digital_input_state == {8'h00, $past(din_rev)}; endproperty
  a_din: assert property (p_din) else $error("input byte order wrong");
  property p_speed; s_on |-> speed_status_word == {{2{$past(speed_feedback[13])}}, $past(speed_feedback)}; endproperty
  a_speed: assert property (p_speed) else $error("speed feedback wrong");
  property p_loss; !link_ok && link_loss_action == 3'h3 |=> !remote_cmd && !start_cmd; endproperty
  a_loss: assert property (p_loss) else $error("go local not applied");
  property p_return; link_ok && !up_q |=> bus_outputs == 5'h00; endproperty
  a_return: assert property (p_return) else $error("outputs not reset on return");
endmodule : fieldbus_pdi_properties
bind fieldbus_process_data_interface fieldbus_pdi_properties u_pdi_props (.*);
`default_nettype wire

/* tb/fieldbus_master_model.sv */
// behavioural fieldbus master: sends the six command words as one set.
// assumes send is raised for one cycle, spaced wider than HOLD_CYCLES.
`default_nettype none
module fieldbus_master_model #(
  parameter int HOLD_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [15:0] word_in [6],
  output logic cmd_strobe,
  output logic [15:0] word_out [6]
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap, next_gap;
  logic next_strobe;
  logic [15:0] next_word [6];
  always_comb begin
    next_gap = (gap > 0) ? gap - 1 : 0;
    next_strobe = 1'b0;
    // words are not held between sets
    for (int i = 0; i < 6; i++) next_word[i] = ~word_out[i];
    // whole set at once with the strobe, then a hold gap
    if (send && gap == 0) begin
      next_strobe = 1'b1;
      next_gap = HOLD_CYCLES;
      next_word = word_in;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      gap <= 0;
      word_out <= '{default: 16'h0000};
    end else begin
      cmd_strobe <= next_strobe;
      gap <= next_gap;
      word_out <= next_word;
    end
  end
endmodule : fieldbus_master_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the process-data interpreter and a behavioural master.
// assumes the defines header, package and design are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int due; int id; logic [15:0] v;} note_t;
  note_t q[$];
  int cyc, error_cnt, tests_run, seed = 47812;
  logic core_clk = 1'b0;
  logic rst, send, master_link_lost, bus_board_inactive, error_active, pid_automatic, undervoltage;
  logic is_remote, jog_active, is_clockwise, is_enabled, is_running, param_done, param_missing;
  logic param_out_of_range, param_read_only, cmd_strobe;
  logic [2:0] bus_protocol_select, link_loss_action;
  logic [7:0] fault_code, digital_inputs, fl, rv;
  logic [4:0] function_bus_assigned, output_bus_assigned, bus_outputs;
  logic [4:0] loss_exp [5] = '{5'h1e, 5'h1d, 5'h1f, 5'h0e, 5'h0f};
  logic signed [13:0] speed_feedback;
  logic signed [15:0] torque_current_value, motor_current_value, max_speed_reference, speed_reference;
  logic [15:0] word_in [6], mw [6], drive_status_word, speed_status_word, digital_input_state;
  logic [15:0] param_readback_word, torque_status_word, motor_status_word, param_read_number;
  logic [15:0] param_write_number, param_write_value;
  logic remote_cmd, jog_cmd, clockwise_cmd, enable_cmd, start_cmd, stop_detect, fault_reset_pulse;
  logic store_limits_nv, param_write_req;
  wire logic [15:0] drive_control_word = mw[0];
  wire logic [15:0] speed_reference_word = mw[1];
  wire logic [15:0] output_command_word = mw[2];
  wire logic [15:0] read_select_word = mw[3];
  wire logic [15:0] write_number_word = mw[4];
  wire logic [15:0] write_value_word = mw[5];
  wire logic [15:0] param_read_data = param_read_number ^ 16'h5a5a;
  fieldbus_master_model #(.HOLD_CYCLES(2)) u_master (.core_clk(core_clk), .rst(rst), .send(send),
    .word_in(word_in), .cmd_strobe(cmd_strobe), .word_out(mw));
  fieldbus_process_data_interface #(.TORQUE_STEP_CYCLES(2), .MOTOR_STEP_CYCLES(1)) DUT (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] obs(input int id);
    case (id)
      0: return drive_status_word;
      1: return speed_status_word;
      2: return digital_input_state;
      3: return param_readback_word;
      4: return torque_status_word;
      5: return {11'h000, remote_cmd, jog_cmd, clockwise_cmd, enable_cmd, start_cmd};
      6: return {13'h0000, stop_detect, fault_reset_pulse, store_limits_nv};
      7: return speed_reference;
      8: return {11'h000, bus_outputs};
      9: return {15'h0000, param_write_req};
      10: return param_write_number;
      11: return param_write_value;
      default: return param_read_number;
    endcase
  endfunction : obs
  task automatic note(input int id, input logic [15:0] v, input int lat);
    q.push_back('{cyc + lat, id, v});
  endtask : note
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic put(input logic [15:0] ctl);
    word_in[0] = ctl;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    tick(3);
  endtask : put
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) cyc <= cyc + 1;
  // oldest due note first
  always @(negedge core_clk) begin
    int i;
    i = 0;
    while (i < q.size()) if (q[i].due == cyc) begin
      chk(obs(q[i].id), q[i].v);
      q.delete(i);
    end else i++;
  end
  initial begin
    int p, wc;
    rst = 1'b1;
    {master_link_lost, bus_board_inactive, error_active, pid_automatic, undervoltage, is_remote, jog_active,
      is_clockwise, is_enabled, is_running, param_done, param_missing, param_out_of_range, param_read_only, send} = '0;
    word_in = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03e7, 16'h0000};
    {bus_protocol_select, link_loss_action, fault_code, digital_inputs, speed_feedback} = '0;
    {function_bus_assigned, output_bus_assigned, torque_current_value, motor_current_value} = {10'h3ff, 32'h0};
    max_speed_reference = 16'sh3000;
    tick(3);
    chk({15'h0000, store_limits_nv}, 16'h0001);
    chk(param_write_number, 16'h03e7);
    rst = 1'b0;
    tick(3);
    for (p = 0; p < 8; p++) begin
      bus_protocol_select = p[2:0];
      fl = 8'($random(seed));
      {error_active, pid_automatic, undervoltage, is_remote, jog_active, is_clockwise, is_enabled, is_running} = fl;
      fault_code = 8'($random(seed));
      speed_feedback = 14'($random(seed));
      digital_inputs = 8'($random(seed));
      for (int i = 0; i < 8; i++) rv[i] = digital_inputs[7 - i];
      wc = (p > 0 && p < 7) ? (p - 1) % 3 + 1 : 0;
      note(0, wc ? {fl, fault_code} : 16'h0000, 1);
      note(1, wc ? {{2{speed_feedback[13]}}, speed_feedback} : 16'h0000, 1);
      note(2, wc > 1 ? {8'h00, rv} : 16'h0000, 1);
      if (wc < 3) note(4, 16'h0000, 1);
      tick(2);
    end
    bus_protocol_select = 3'h6;
    {error_active, pid_automatic, undervoltage, is_remote, jog_active, is_clockwise, is_enabled, is_running} = 8'h01;
    fault_code = 8'h00;
    tick(3);
    word_in[1] = 16'h0b8e;
    word_in[2] = 16'h1f15;
    note(5, 16'h001f, 2);
    note(7, 16'h0b8e, 2);
    note(8, 16'h0015, 2);
    put(16'h1f1f);
    word_in[1] = 16'h7fff;
    word_in[2] = 16'h0100;
    note(5, 16'h0010, 2);
    note(6, 16'h0005, 2);
    note(7, 16'h3000, 2);
    note(8, 16'h0014, 2);
    put(16'h0f40);
    note(6, 16'h0000, 2);
    put(16'h2020);
    note(6, 16'h0002, 2);
    note(6, 16'h0000, 3);
    put(16'h8080);
    note(6, 16'h0001, 2);
    put(16'h2000);
    word_in[3] = 16'h0006;
    note(3, 16'h0001, 3);
    put(16'h0000);
    word_in[3] = 16'h0064;
    note(12, 16'h0064, 2);
    note(3, 16'h0064 ^ 16'h5a5a, 3);
    put(16'h0000);
    word_in[4] = 16'h0064;
    word_in[5] = 16'h0005;
    note(9, 16'h0001, 2);
    note(9, 16'h0000, 3);
    note(10, 16'h0064, 2);
    note(11, 16'h0005, 2);
    put(16'h0000);
    is_enabled = 1'b1;
    word_in[4] = 16'h0065;
    note(9, 16'h0000, 2);
    note(0, 16'h0318, 4);
    put(16'h0000);
    is_enabled = 1'b0;
    word_in[4] = 16'h03e7;
    note(0, 16'h0100, 4);
    put(16'h0000);
    for (p = 0; p < 4; p++) begin
      {param_missing, param_out_of_range, param_read_only} = 3'b100 >> p;
      param_done = 1'b1;
      note(0, p == 3 ? 16'h0100 : 16'(16'h0119 + p), 3);
      tick(1);
      param_done = 1'b0;
      tick(3);
    end
    word_in[2] = 16'h1f15;
    for (p = 0; p < 5; p++) begin
      put(16'h1f1f);
      link_loss_action = p[2:0];
      {master_link_lost, bus_board_inactive} = p[0] ? 2'b10 : 2'b01;
      note(5, {11'h000, loss_exp[p]}, 2);
      tick(2);
      {master_link_lost, bus_board_inactive} = 2'b00;
      note(8, 16'h0000, 2);
      tick(3);
    end
    torque_current_value = 16'sh1000;
    motor_current_value = 16'sh1000;
    tick(256);
    chk({15'h0000, motor_status_word inside {[16'h0900:16'h0b00]}}, 16'h0001);
    chk({15'h0000, torque_status_word inside {[16'h0580:16'h0720]}}, 16'h0001);
    for (p = 0; p < 20 && q.size() > 0; p++) tick(1);
    if (q.size() > 0) error_cnt++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
